// ### core/pis_cfg.svh
// constants for the event-mask/charger-status register bank
// assumes inclusion by bare name from every file that needs an offset or field position
`ifndef PIS_CFG_SVH
`define PIS_CFG_SVH

// register byte addresses on the serial management bus
`define PIS_INT_ADDR 8'h02
`define PIS_CHG_ADDR 8'h03
`define PIS_LIVE_ADDR 8'h0A

// reset values
`define PIS_INT_RESET 8'h80
`define PIS_CHG_RESET 8'h00
`define PIS_MASK_RESET 3'h0
`define PIS_RSV7_RESET 1'b1

// field positions inside the interrupt register
`define PIS_RSV7_BIT 7
`define PIS_BTN_MASK_BIT 6
`define PIS_WALL_MASK_BIT 5
`define PIS_BUS_MASK_BIT 4
`define PIS_RSV3_BIT 3
`define PIS_BTN_FLAG_BIT 2
`define PIS_WALL_FLAG_BIT 1
`define PIS_BUS_FLAG_BIT 0

// number of maskable events and the 7-bit bus address (address value is arbitrary)
`define PIS_NUM_EVENTS 3
`define PIS_DEV_ADDR 7'h10

`endif

// ### core/pis_event_flag.sv
// one sticky change-event flag with its own level watcher
// assumes level is synchronous to clock and clear is a one-cycle pulse
`timescale 1ns/1ps

module pis_event_flag (
    input wire logic clock,
    input wire logic nrst,
    input wire logic level,
    input wire logic clear,
    output logic flag
);

    logic prev; // level seen one cycle ago
    logic armed; // low until the first level has been captured
    logic change; // level differs from last cycle

    // no change is reported in the first cycle after reset, so a level that is
    // already high at power-up does not fake an event
    assign change = armed & (level != prev);

    ////////////////////////////////////////////////////////////////////////////
    // level history
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prev <= 1'b0;
            armed <= 1'b0;
        end else begin
            prev <= level;
            armed <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky flag: a change in the clearing cycle wins, so no event is lost
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flag <= 1'b0;
        end else begin
            flag <= change | (flag & ~clear);
        end
    end

endmodule : pis_event_flag

// ### core/pis_pkg.sv
// types shared by the register bank
// assumes nothing of its surroundings
package pis_pkg;

    // serial slave sequencer states
    typedef enum logic [3:0] {
        st_idle,
        st_addr,
        st_addr_ack,
        st_ptr,
        st_ptr_ack,
        st_wr,
        st_wr_ack,
        st_rd,
        st_rd_ack
    } pis_state_e;

endpackage : pis_pkg

// ### core/pis_regbank.sv
// event-mask/flag register and charger status register behind a serial slave
// assumes scl_in/sda_in are already synchronous to clock and the pad resolves sda
// Functional notes
// - button change mask bit 6, reset 0
// - wall input mask bit 5, reset 0
// - bus input mask bit 4, reset 0
// - button flag bit 2 set on any edge
// - wall flag bit 1 set on change
// - bus flag bit 0 set on change
// - bit 3 reads 0; bit 7 rw, reset 1
// - present levels readable from separate live register
// - charger status read-only, reset 0x00
// - bit 7 shows thermal current reduction
// - bit 6 shows input power limiting
// - bit 5 shows temperature charge suspend
// - bit 4 shows termination reached
// - bit 3 shows charger actively charging
// - bit 2 shows charge timer expired
// - bit 1 shows precharge timer expired
// - bit 0 shows sensor missing or temperature fault
`timescale 1ns/1ps
`include "pis_cfg.svh"

module pis_regbank #(
    parameter logic [6:0] DEV_ADDR = `PIS_DEV_ADDR // bus address, value arbitrary
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic button_input_pin,
    input wire logic wall_input_present,
    input wire logic bus_input_present,
    input wire logic thermal_limit_active,
    input wire logic input_power_limit_active,
    input wire logic temp_suspend,
    input wire logic charge_terminated,
    input wire logic charger_active,
    input wire logic charge_timer_expired,
    input wire logic precharge_timer_expired,
    input wire logic battery_temp_fault,
    output logic irq_n
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    pis_pkg::pis_state_e state; // serial sequencer state
    logic [2:0] bit_cnt; // bit position inside the current byte
    logic ack_phase; // high after the first falling scl of an ack slot
    logic rw_read; // last address byte asked for a read
    logic [7:0] rx_shift; // incoming byte
    logic [7:0] tx_shift; // outgoing byte, msb on the wire
    logic drive_low; // pull sda low
    logic [7:0] ptr; // register pointer, auto-increments
    logic scl_q; // scl one cycle ago
    logic sda_q; // sda one cycle ago

    logic [`PIS_NUM_EVENTS-1:0] ev_level; // watched input levels
    logic [`PIS_NUM_EVENTS-1:0] ev_flag; // sticky change flags
    logic [`PIS_NUM_EVENTS-1:0] ev_mask; // 1 hides the event from irq_n
    logic rsv7; // reserved read/write bit
    logic [7:0] chg_status; // captured charger status
    logic [7:0] read_data; // byte selected by ptr

    logic start_det; // sda falls while scl high
    logic stop_det; // sda rises while scl high
    logic scl_rise;
    logic scl_fall;
    logic rx_state; // sequencer is shifting a byte in
    logic rx_done; // eighth bit of an incoming byte sampled
    logic [7:0] rx_byte; // complete incoming byte at rx_done
    logic ack_state; // sequencer sits in an ack slot it drives
    logic ack_drive; // start pulling low for ack
    logic ack_end; // end of an ack slot
    logic load_tx; // fetch next read byte
    logic tx_next_bit; // shift out the next read bit
    logic tx_done; // last read bit finished
    logic reg_wr; // a data byte arrived for ptr
    logic int_read_clr; // interrupt register being read

    ////////////////////////////////////////////////////////////////////////////
    // bus conditions

    // the pad is open drain: only a low is ever driven
    assign sda_out = 1'b0;
    assign sda_oe = drive_low;

    assign start_det = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_det = scl_in & scl_q & ~sda_q & sda_in;
    assign scl_rise = scl_in & ~scl_q;
    assign scl_fall = ~scl_in & scl_q;

    assign rx_state = (state == pis_pkg::st_addr) | (state == pis_pkg::st_ptr) | (state == pis_pkg::st_wr);
    assign rx_done = rx_state & scl_rise & (bit_cnt == 3'h7);
    assign rx_byte = {rx_shift[6:0], sda_in};
    assign ack_state = (state == pis_pkg::st_addr_ack) | (state == pis_pkg::st_ptr_ack) |
                       (state == pis_pkg::st_wr_ack);
    assign ack_drive = ack_state & scl_fall & ~ack_phase;
    assign ack_end = ack_state & scl_fall & ack_phase;
    assign load_tx = ((state == pis_pkg::st_addr_ack) & ack_end & rw_read) |
                     ((state == pis_pkg::st_rd_ack) & scl_fall);
    assign tx_next_bit = (state == pis_pkg::st_rd) & scl_fall & (bit_cnt != 3'h7);
    assign tx_done = (state == pis_pkg::st_rd) & scl_fall & (bit_cnt == 3'h7);
    assign reg_wr = rx_done & (state == pis_pkg::st_wr);
    // fetching the byte clears the flags it carries; a new event still wins
    assign int_read_clr = load_tx & (ptr == `PIS_INT_ADDR);

    ////////////////////////////////////////////////////////////////////////////
    // line history for edge and start/stop detection
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: address, pointer, write data, read data and their ack slots
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= pis_pkg::st_idle;
            bit_cnt <= 3'h0;
            ack_phase <= 1'b0;
            rw_read <= 1'b0;
        end else if (start_det) begin
            // a repeated start restarts from the address byte at any point
            state <= pis_pkg::st_addr;
            bit_cnt <= 3'h0;
            ack_phase <= 1'b0;
        end else if (stop_det) begin
            state <= pis_pkg::st_idle;
            bit_cnt <= 3'h0;
            ack_phase <= 1'b0;
        end else begin
            case (state)
                pis_pkg::st_addr, pis_pkg::st_ptr, pis_pkg::st_wr: begin
                    if (scl_rise) begin
                        bit_cnt <= bit_cnt + 3'h1;
                    end
                    if (rx_done) begin
                        ack_phase <= 1'b0;
                        if (state == pis_pkg::st_addr) begin
                            rw_read <= rx_byte[0];
                            // a foreign address leaves the bus alone until the next start
                            state <= (rx_byte[7:1] == DEV_ADDR) ? pis_pkg::st_addr_ack : pis_pkg::st_idle;
                        end else if (state == pis_pkg::st_ptr) begin
                            state <= pis_pkg::st_ptr_ack;
                        end else begin
                            state <= pis_pkg::st_wr_ack;
                        end
                    end
                end
                pis_pkg::st_addr_ack, pis_pkg::st_ptr_ack, pis_pkg::st_wr_ack: begin
                    if (scl_fall) begin
                        if (!ack_phase) begin
                            ack_phase <= 1'b1;
                        end else begin
                            ack_phase <= 1'b0;
                            bit_cnt <= 3'h0;
                            if (state == pis_pkg::st_addr_ack) begin
                                state <= rw_read ? pis_pkg::st_rd : pis_pkg::st_ptr;
                            end else begin
                                state <= pis_pkg::st_wr;
                            end
                        end
                    end
                end
                pis_pkg::st_rd: begin
                    if (scl_fall) begin
                        if (bit_cnt == 3'h7) begin
                            state <= pis_pkg::st_rd_ack;
                            bit_cnt <= 3'h0;
                        end else begin
                            bit_cnt <= bit_cnt + 3'h1;
                        end
                    end
                end
                pis_pkg::st_rd_ack: begin
                    if (scl_rise && sda_in) begin
                        // master nack: stop sending, wait for stop or start
                        state <= pis_pkg::st_idle;
                    end else if (scl_fall) begin
                        state <= pis_pkg::st_rd;
                        bit_cnt <= 3'h0;
                    end
                end
                default: begin
                    state <= pis_pkg::st_idle;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // incoming shift register, sampled on rising scl
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rx_shift <= 8'h00;
        end else if (rx_state && scl_rise) begin
            rx_shift <= rx_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sda driver: ack low, read bits msb first, released on start/stop
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tx_shift <= 8'h00;
            drive_low <= 1'b0;
        end else if (start_det || stop_det) begin
            drive_low <= 1'b0;
        end else if (ack_drive) begin
            drive_low <= 1'b1;
        end else if (load_tx) begin
            // byte captured at the fetch, so the read shows the flags that are cleared
            tx_shift <= read_data;
            drive_low <= ~read_data[7];
        end else if (ack_end) begin
            drive_low <= 1'b0;
        end else if (tx_next_bit) begin
            tx_shift <= {tx_shift[6:0], 1'b0};
            drive_low <= ~tx_shift[6];
        end else if (tx_done) begin
            // hand sda to the master for its ack bit
            drive_low <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register pointer: set by the first written byte, steps after each data byte
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ptr <= 8'h00;
        end else if (rx_done && (state == pis_pkg::st_ptr)) begin
            ptr <= rx_byte;
        end else if (reg_wr || load_tx) begin
            ptr <= ptr + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // writable bits of the interrupt register; writes to other addresses,
    // the charger status included, are dropped
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ev_mask <= `PIS_MASK_RESET;
            rsv7 <= `PIS_RSV7_RESET;
        end else if (reg_wr && (ptr == `PIS_INT_ADDR)) begin
            ev_mask[`PIS_BTN_FLAG_BIT] <= rx_byte[`PIS_BTN_MASK_BIT];
            ev_mask[`PIS_WALL_FLAG_BIT] <= rx_byte[`PIS_WALL_MASK_BIT];
            ev_mask[`PIS_BUS_FLAG_BIT] <= rx_byte[`PIS_BUS_MASK_BIT];
            rsv7 <= rx_byte[`PIS_RSV7_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // change watchers, one per event, index equals the flag's bit position
    assign ev_level[`PIS_BTN_FLAG_BIT] = button_input_pin;
    assign ev_level[`PIS_WALL_FLAG_BIT] = wall_input_present;
    assign ev_level[`PIS_BUS_FLAG_BIT] = bus_input_present;

    genvar gi;
    generate
        for (gi = 0; gi < `PIS_NUM_EVENTS; gi = gi + 1) begin : g_event
            pis_event_flag u_flag (
                .clock(clock),
                .nrst(nrst),
                .level(ev_level[gi]),
                .clear(int_read_clr),
                .flag(ev_flag[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // charger status capture; loop signals are levels, no stickiness here
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            chg_status <= `PIS_CHG_RESET;
        end else begin
            chg_status[7] <= thermal_limit_active;
            chg_status[6] <= input_power_limit_active;
            chg_status[5] <= temp_suspend;
            chg_status[4] <= charge_terminated;
            chg_status[3] <= charger_active;
            chg_status[2] <= charge_timer_expired;
            chg_status[1] <= precharge_timer_expired;
            // a zero here does not prove a good temperature, only no fault seen
            chg_status[0] <= battery_temp_fault;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read multiplexer; unmapped addresses read zero
    always_comb begin
        read_data = 8'h00;
        case (ptr)
            `PIS_INT_ADDR: begin
                read_data[`PIS_RSV7_BIT] = rsv7;
                read_data[`PIS_BTN_MASK_BIT] = ev_mask[`PIS_BTN_FLAG_BIT];
                read_data[`PIS_WALL_MASK_BIT] = ev_mask[`PIS_WALL_FLAG_BIT];
                read_data[`PIS_BUS_MASK_BIT] = ev_mask[`PIS_BUS_FLAG_BIT];
                read_data[`PIS_RSV3_BIT] = 1'b0;
                read_data[`PIS_BTN_FLAG_BIT] = ev_flag[`PIS_BTN_FLAG_BIT];
                read_data[`PIS_WALL_FLAG_BIT] = ev_flag[`PIS_WALL_FLAG_BIT];
                read_data[`PIS_BUS_FLAG_BIT] = ev_flag[`PIS_BUS_FLAG_BIT];
            end
            `PIS_CHG_ADDR: begin
                read_data = chg_status;
            end
            `PIS_LIVE_ADDR: begin
                // present levels, separate from the change flags
                read_data[`PIS_NUM_EVENTS-1:0] = ev_level;
            end
            default: begin
                read_data = 8'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt line, registered to keep it glitch free
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= ~|(ev_flag & ~ev_mask);
        end
    end

endmodule : pis_regbank

// ### sim/pis_host_model.sv
// serial bus host model with register read and write tasks
// assumes a pulled-up data line that the device sinks through sda_oe
`timescale 1ns/1ps

module pis_host_model (
    input wire logic clock,
    input wire logic sda_out,
    input wire logic sda_oe,
    output logic scl_in,
    output logic sda_in
);
    logic scl_q = 1'b1; // host clock drive, idles high
    logic sda_q = 1'b1; // host data drive, 1 releases the line
    logic [3:0] gap = 4'h4; // cycles per third of a bit; the bench may slow it
    // wired-and; a released line reads the pull-up, never a stale value
    assign sda_in = sda_q & (sda_oe ? sda_out : 1'b1);
    assign scl_in = scl_q;
    ////////////////////////////////////////////////////////////////////////
    // four cycles or more keeps every half period above the three-cycle floor
    task automatic half();
        repeat (gap) @(posedge clock);
    endtask : half
    // also serves as repeated start: data rises while the clock is low
    task automatic start();
        sda_q <= 1'b1;
        half();
        scl_q <= 1'b1;
        half();
        sda_q <= 1'b0;
        half();
        scl_q <= 1'b0;
        half();
    endtask : start
    task automatic stop();
        sda_q <= 1'b0;
        half();
        scl_q <= 1'b1;
        half();
        sda_q <= 1'b1;
        half();
    endtask : stop
    // data moves only while the clock is low; the line is read just before the fall
    task automatic bit_io(input logic b, output logic r);
        sda_q <= b;
        half();
        scl_q <= 1'b1;
        half();
        r = sda_in;
        scl_q <= 1'b0;
        half();
    endtask : bit_io
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_in, ack);
    endtask : xfer
    task automatic wr(input logic [6:0] a, input logic [7:0] ptr, input logic [7:0] dat, output logic nak);
        logic [7:0] rx;
        logic a0, a1, a2;
        start();
        xfer({a, 1'b0}, 1'b1, rx, a0);
        xfer(ptr, 1'b1, rx, a1);
        xfer(dat, 1'b1, rx, a2);
        stop();
        nak = a0 | a1 | a2;
    endtask : wr
    // single byte read, closed by a host nack
    task automatic rd(input logic [6:0] a, input logic [7:0] ptr, output logic [7:0] dat, output logic nak);
        logic [7:0] rx;
        logic a0, a1, a2, a3;
        start();
        xfer({a, 1'b0}, 1'b1, rx, a0);
        xfer(ptr, 1'b1, rx, a1);
        start();
        xfer({a, 1'b1}, 1'b1, rx, a2);
        xfer(8'hFF, 1'b1, dat, a3);
        stop();
        nak = a0 | a1 | a2;
    endtask : rd
    // burst of two, the first acked
    task automatic rd2(input logic [6:0] a, input logic [7:0] ptr, output logic [15:0] dat, output logic nak);
        logic a0, a1, a2, a3;
        start();
        xfer({a, 1'b0}, 1'b1, dat[7:0], a0);
        xfer(ptr, 1'b1, dat[7:0], a1);
        start();
        xfer({a, 1'b1}, 1'b1, dat[7:0], a2);
        xfer(8'hFF, 1'b0, dat[15:8], a3);
        xfer(8'hFF, 1'b1, dat[7:0], a3);
        stop();
        nak = a0 | a1 | a2;
    endtask : rd2
endmodule : pis_host_model

// ### sim/pis_regbank_sva.sv
// checker for the interrupt output of the register bank
// assumes binding to pis_regbank; sees only its ports
`timescale 1ns/1ps

module pis_regbank_sva (
    input wire logic clock,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic button_input_pin,
    input wire logic wall_input_present,
    input wire logic bus_input_present,
    input wire logic thermal_limit_active,
    input wire logic input_power_limit_active,
    input wire logic temp_suspend,
    input wire logic charge_terminated,
    input wire logic charger_active,
    input wire logic charge_timer_expired,
    input wire logic precharge_timer_expired,
    input wire logic battery_temp_fault,
    input wire logic irq_n
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////
    logic [2:0] lv_d1, lv_d2, lv_d3, lv_d4; // level history: button, wall, bus
    logic [2:0] ev; // a change two or three edges back
    logic any_ev; // some change seen since reset
    logic scl_d, sda_d, in_frame; // bus between start and stop
    // two ages are allowed, since the flag may land one edge late
    assign ev = (lv_d2 ^ lv_d3) | (lv_d3 ^ lv_d4);
    // level history; zero reset is safe, the inputs sit low in reset
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lv_d1 <= 3'h0;
            lv_d2 <= 3'h0;
            lv_d3 <= 3'h0;
            lv_d4 <= 3'h0;
            any_ev <= 1'b0;
        end else begin
            lv_d1 <= {button_input_pin, wall_input_present, bus_input_present};
            lv_d2 <= lv_d1;
            lv_d3 <= lv_d2;
            lv_d4 <= lv_d3;
            any_ev <= any_ev | (|(lv_d1 ^ lv_d2));
        end
    end
    // start and stop are data moves while the bus clock stays high
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            in_frame <= 1'b0;
        end else begin
            scl_d <= scl_in;
            sda_d <= sda_in;
            if (scl_in && scl_d && sda_d && !sda_in) begin
                in_frame <= 1'b1;
            end else if (scl_in && scl_d && !sda_d && sda_in) begin
                in_frame <= 1'b0;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    btn_irq_a: assert property ($fell(irq_n) && !in_frame && ev[1:0] == 2'h0 |-> ev[2])
        else $error("irq fell without a button change");
    wall_irq_a: assert property ($fell(irq_n) && !in_frame && ev[2] == 1'b0 && ev[0] == 1'b0 |-> ev[1])
        else $error("irq fell without a wall input change");
    bus_irq_a: assert property ($fell(irq_n) && !in_frame && ev[2:1] == 2'h0 |-> ev[0])
        else $error("irq fell without a bus input change");
    irq_cause_a: assert property (!irq_n |-> any_ev)
        else $error("irq low with no level change since reset");
    irq_release_a: assert property ($rose(irq_n) |-> in_frame)
        else $error("irq released outside a bus transfer");
    flag_hold_a: assert property (!irq_n && !in_frame |=> !irq_n)
        else $error("pending event dropped without a read");
    irq_width_a: assert property ($fell(irq_n) |=> (!irq_n) [*3])
        else $error("irq pulse shorter than any read");
    reset_quiet_a: assert property ($rose(nrst) |-> irq_n ##1 irq_n)
        else $error("event raised right after reset");
endmodule : pis_regbank_sva

bind pis_regbank pis_regbank_sva u_sva (
    .clock(clock), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .button_input_pin(button_input_pin), .wall_input_present(wall_input_present),
    .bus_input_present(bus_input_present), .thermal_limit_active(thermal_limit_active),
    .input_power_limit_active(input_power_limit_active), .temp_suspend(temp_suspend),
    .charge_terminated(charge_terminated), .charger_active(charger_active),
    .charge_timer_expired(charge_timer_expired), .precharge_timer_expired(precharge_timer_expired),
    .battery_temp_fault(battery_temp_fault), .irq_n(irq_n)
);

// ### sim/pis_regbank_tb_top.sv
// self-checking bench: bus register accesses plus level stimulus
// assumes the host model resolves the data line and the checker is bound
`timescale 1ns/1ps

module pis_regbank_tb_top;
    localparam logic [6:0] DEV = 7'h10; // bus address, value arbitrary
    logic clock = 1'b0;
    logic nrst; // active-low reset
    logic scl_in, sda_in, sda_out, sda_oe, irq_n;
    logic [2:0] lv; // button, wall, bus levels
    logic [7:0] chg; // charger state levels, bit 7 down to 0
    logic nak; // host saw no acknowledge
    logic [15:0] two; // burst bytes
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    always #50 clock = ~clock;
    pis_regbank #(.DEV_ADDR(DEV)) dut (
        .clock(clock), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .button_input_pin(lv[2]), .wall_input_present(lv[1]), .bus_input_present(lv[0]),
        .thermal_limit_active(chg[7]), .input_power_limit_active(chg[6]), .temp_suspend(chg[5]),
        .charge_terminated(chg[4]), .charger_active(chg[3]), .charge_timer_expired(chg[2]),
        .precharge_timer_expired(chg[1]), .battery_temp_fault(chg[0]), .irq_n(irq_n)
    );
    pis_host_model host (.clock(clock), .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp, input string what);
        logic [7:0] got;
        host.rd(DEV, ptr, got, nak);
        check({7'h00, nak}, 8'h00, "read ack");
        check(got, exp, what);
    endtask : rd_chk
    task automatic wr_do(input logic [7:0] ptr, input logic [7:0] dat);
        host.wr(DEV, ptr, dat, nak);
        check({7'h00, nak}, 8'h00, "write ack");
    endtask : wr_do
    task automatic print_verdict();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    // hang guard, well above the run length
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        lv = 3'h0;
        chg = 8'h00;
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        rd_chk(8'h02, 8'h80, "int reset");
        rd_chk(8'h03, 8'h00, "chg reset");
        host.wr(7'h11, 8'h02, 8'h00, nak);
        check({7'h00, nak}, 8'h01, "foreign nak");
        rd_chk(8'h02, 8'h80, "foreign ignored");
        wr_do(8'h02, 8'h7F);
        rd_chk(8'h02, 8'h70, "rw fields");
        wr_do(8'h02, 8'h80);
        // each event unmasked, both directions of every level
        for (int k = 0; k < 6; k++) begin
            lv[k % 3] <= ~lv[k % 3];
            repeat (4) @(posedge clock);
            check({7'h00, irq_n}, 8'h00, "irq asserted");
            rd_chk(8'h0A, {5'h00, lv}, "live levels");
            rd_chk(8'h02, 8'h80 | (8'h01 << (k % 3)), "event flag");
            check({7'h00, irq_n}, 8'h01, "irq released");
            rd_chk(8'h02, 8'h80, "flag cleared");
        end
        // a masked event still sets its flag but keeps the output quiet
        for (int k = 0; k < 3; k++) begin
            wr_do(8'h02, 8'h80 | (8'h40 >> k));
            lv[2 - k] <= ~lv[2 - k];
            repeat (4) @(posedge clock);
            check({7'h00, irq_n}, 8'h01, "irq masked");
            rd_chk(8'h02, 8'h80 | (8'h40 >> k) | (8'h04 >> k), "masked flag");
        end
        // slower host pace; every status bit alone, writes must not stick
        host.gap = 4'h9;
        for (int j = 0; j < 8; j++) begin
            chg <= 8'h01 << j;
            wr_do(8'h03, ~(8'h01 << j));
            rd_chk(8'h03, 8'h01 << j, "charger bit");
        end
        host.rd2(DEV, 8'h03, two, nak);
        check(two[15:8], 8'h80, "burst chg");
        check(two[7:0] | {7'h00, nak}, 8'h00, "burst next");
        print_verdict();
    end
endmodule : pis_regbank_tb_top
